// file: dfkp_pkg.sv
// Package: constants, types and codes for the drive fault keypad panel
// How it works
// [RULE_01] Jog drives set velocity while plus or minus held, zero on release.
// [RULE_02] Up to sixteen enabled position registers compared against actual position.
// [RULE_03] Baud code decodes to kbit/s per the fixed coding table.
// [RULE_04] New address or baud code applies only after a power cycle.
// [RULE_05] Standard menu by default; advanced only if right key held at power-up.
// [RULE_06] Up press: next item or plus one; rapid double press plus ten.
// [RULE_07] Down press: minus one; rapid double press minus ten.
// [RULE_08] Right held then left pressed confirms the edited number.
// [RULE_09] Edited station address stored automatically when leaving the field.
// [RULE_10] Active fault shown on display as its fault number.
// [RULE_11] Any fault opens ready contact, disables output stage, applies brake.
// [RULE_12] Status codes: normal, updating, programming, restart lock low while disabled.
// [RULE_13] F01 heat sink over threshold, default 80 C, clearable.
// [RULE_14] F05 DC bus undervoltage, default 100 V, clearable.
// [RULE_15] Fault numbers F02 to F14 assigned to their causes.
// [RULE_16] Fault numbers F15 to F32 assigned to their causes.
// [RULE_17] F22 and F31 never raised; F24 warning as fault; F30 e-stop timeout.
// [RULE_18] F27 when restart lock enable and hardware enable rise together.
// [RULE_19] Faults 1,2,3,5,8,13,16,19 clear by clear command; others need reset.
// [RULE_20] Reset with exactly one clearable fault only clears faults.
// [RULE_21] Warnings shown as codes while ready contact and output stage stay on.
// [RULE_22] Double press needs second press within a window after first release.
// [RULE_23] Keys and fault inputs debounced over a set number of cycles.
package dfkp_pkg;
	localparam int unsigned NUM_FAULTS    = 32;
	localparam int unsigned NUM_POSREG    = 16;
	localparam int unsigned DEB_CYCLES    = 16;
	localparam int unsigned DBL_WINDOW    = 64;
	localparam int unsigned CLK_MHZ       = 250;
	// Fault bit i stands for fault number i+1
	localparam logic [31:0] CLEARABLE_MASK = 32'h0004_9097;
	localparam logic [31:0] RESERVED_MASK  = 32'h4020_0000;
	localparam logic [7:0]  HEAT_LIMIT_C   = 8'h50;
	localparam logic [11:0] UNDERVOLT_V    = 12'h064;
	localparam logic [6:0]  ADDR_MAX       = 7'h7f;
	// Display codes for status
	localparam logic [7:0]  DISP_NORMAL    = 8'h00;
	localparam logic [7:0]  DISP_UPDATING  = 8'hf1;
	localparam logic [7:0]  DISP_PROGRAM   = 8'hf2;
	localparam logic [7:0]  DISP_RLOCK     = 8'hf3;
	localparam logic [7:0]  DISP_WARN_BASE = 8'h80;
	// AXI4-Lite register map
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_JOG_VEL    = 8'h04;
	localparam logic [7:0]  REG_STATUS     = 8'h08;
	localparam logic [7:0]  REG_FAULTS     = 8'h0c;
	localparam logic [7:0]  REG_CONFIG     = 8'h10;
	localparam logic [7:0]  REG_POS_EN     = 8'h14;
	localparam logic [7:0]  REG_POS_HIT    = 8'h18;
	localparam logic [7:0]  REG_POS_BASE   = 8'h40;
	localparam logic [1:0]  RESP_OKAY      = 2'b00;
	localparam logic [1:0]  RESP_SLVERR    = 2'b10;

	typedef struct packed {
		logic ready_contact;
		logic stage_on;
		logic brake_on;
	} dfkp_safe_t;

	typedef enum logic [1:0] {
		DFKP_IDLE = 2'b00,
		DFKP_DOWN = 2'b01,
		DFKP_WAIT = 2'b11
	} dfkp_key_st_t;

	// Baud code to kbit/s; zero means not a valid code
	function automatic logic [15:0] baud_kbps(input logic [7:0] code);
		unique case (code)
			8'h01:   baud_kbps = 16'h000a;
			8'h02:   baud_kbps = 16'h0014;
			8'h05:   baud_kbps = 16'h0032;
			8'h0a:   baud_kbps = 16'h0064;
			8'h0c:   baud_kbps = 16'h007d;
			8'h19:   baud_kbps = 16'h00fa;
			8'h21:   baud_kbps = 16'h014d;
			8'h32:   baud_kbps = 16'h01f4;
			8'h42:   baud_kbps = 16'h029a;
			8'h50:   baud_kbps = 16'h0320;
			8'h64:   baud_kbps = 16'h03e8;
			default: baud_kbps = 16'h0000;
		endcase
	endfunction
endpackage

// file: dfkp_panel.sv
// Front panel supervisory logic: keys, menus, fault handling, AXI4-Lite registers
module dfkp_panel (
	// Clock and reset
	input  wire logic                 clk_in,
	input  wire logic                 rst_n_in,
	// Keys and enables (pins)
	input  wire logic                 key_up_in,
	input  wire logic                 key_down_in,
	input  wire logic                 key_right_in,
	input  wire logic                 key_left_in,
	input  wire logic                 jog_plus_in,
	input  wire logic                 jog_minus_in,
	input  wire logic                 restart_lock_enable_in,
	input  wire logic                 hw_enable_in,
	input  wire logic                 reset_button_in,
	// Fault sources (bit i = fault i+1), pins
	input  wire logic [31:0]          fault_src_in,
	input  wire logic [31:0]          warning_in,
	input  wire logic [7:0]           heatsink_temp_in,
	input  wire logic [11:0]          dc_bus_volt_in,
	input  wire logic                 warn_as_fault_in,
	input  wire logic                 estop_timeout_in,
	input  wire logic                 updating_in,
	input  wire logic [31:0]          actual_pos_in,
	// AXI4-Lite slave
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// Power stage and display
	output dfkp_pkg::dfkp_safe_t      safe_out,
	output logic [15:0]               jog_vel_out,
	output logic [7:0]                display_out,
	output logic                      advanced_menu_out,
	output logic [6:0]                station_addr_out,
	output logic [15:0]               baud_kbps_out,
	output logic [15:0]               pos_hit_out
);
	logic       rst_s1, rst_n;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Two-flop sync then debounce on every single-bit key, enable and status pin (not reset or AXI4-Lite) and on the fault and warning words
	localparam int NP = 78;
	logic [NP-1:0] raw, s1, s2, deb;
	assign raw = {key_up_in, key_down_in, key_right_in, key_left_in, jog_plus_in, jog_minus_in,
		restart_lock_enable_in, hw_enable_in, reset_button_in, warn_as_fault_in, estop_timeout_in,
		updating_in, fault_src_in, warning_in, 2'b00};
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= '0;
			s2 <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NP; g++) begin : g_deb
			logic [4:0] cnt;
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					cnt      <= '0;
					deb[g]   <= 1'b0;
				end else if (s2[g] == deb[g]) begin
					cnt <= '0;
				end else if (cnt == 5'(dfkp_pkg::DEB_CYCLES - 1)) begin
					cnt    <= '0;
					deb[g] <= s2[g]; // RULE_23
				end else begin
					cnt <= cnt + 5'd1;
				end
			end
		end
	endgenerate
	logic k_up, k_dn, k_rt, k_lt, j_p, j_m, rl_en, hw_en, rst_btn, waf, eto, upd;
	logic [31:0] f_src, warn;
	assign {k_up, k_dn, k_rt, k_lt, j_p, j_m, rl_en, hw_en, rst_btn, waf, eto, upd} = deb[77:66];
	assign f_src = deb[65:34];
	assign warn  = deb[33:2];
	// Analog levels sampled twice; they are multi-bit and slow so no debounce
	logic [7:0]  temp_s1, temp_s2;
	logic [11:0] volt_s1, volt_s2;
	logic [31:0] pos_s1, pos_s2;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			temp_s1 <= '0;
			temp_s2 <= '0;
			volt_s1 <= 12'hfff;
			volt_s2 <= 12'hfff;
			pos_s1  <= '0;
			pos_s2  <= '0;
		end else begin
			temp_s1 <= heatsink_temp_in;
			temp_s2 <= temp_s1;
			volt_s1 <= dc_bus_volt_in;
			volt_s2 <= volt_s1;
			pos_s1  <= actual_pos_in;
			pos_s2  <= pos_s1;
		end
	end

	// Key press detection with double-press window
	logic up_d, dn_d, lt_d, cfm;
	logic [7:0] up_win, dn_win;
	logic up_one, up_ten, dn_one, dn_ten;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			up_d   <= 1'b0;
			dn_d   <= 1'b0;
			lt_d   <= 1'b0;
			up_win <= '0;
			dn_win <= '0;
		end else begin
			up_d <= k_up;
			dn_d <= k_dn;
			lt_d <= k_lt;
			if (!k_up && up_d)
				up_win <= 8'(dfkp_pkg::DBL_WINDOW); // RULE_22
			else if (up_win != 8'h00)
				up_win <= up_win - 8'h01;
			if (!k_dn && dn_d)
				dn_win <= 8'(dfkp_pkg::DBL_WINDOW);
			else if (dn_win != 8'h00)
				dn_win <= dn_win - 8'h01;
		end
	end
	// The first press already stepped one; a quick second press adds nine more
	assign up_one = k_up && !up_d && up_win == 8'h00;
	assign up_ten = k_up && !up_d && up_win != 8'h00; // RULE_22
	assign dn_one = k_dn && !dn_d && dn_win == 8'h00;
	assign dn_ten = k_dn && !dn_d && dn_win != 8'h00;
	assign cfm    = k_lt && !lt_d && k_rt; // RULE_08

	// Menu mode follows the right key until the debounced pins have settled after reset, then holds
	logic [5:0]  menu_settle;
	logic [15:0] edit_num;
	logic [3:0]  menu_item;
	logic [6:0]  addr_store = 7'h00; // Nonvolatile: kept across reset
	logic [7:0]  baud_store = 8'h01;
	logic        editing;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			menu_settle       <= '0;
			advanced_menu_out <= 1'b0;
		end else if (menu_settle != 6'(dfkp_pkg::DEB_CYCLES + 8)) begin
			menu_settle       <= menu_settle + 6'd1;
			advanced_menu_out <= k_rt; // RULE_05
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			edit_num   <= '0;
			menu_item  <= '0;
			editing    <= 1'b0;
		end else begin
			if (!editing && up_one)
				menu_item <= menu_item + 4'd1; // RULE_06
			else if (editing && up_one)
				edit_num <= edit_num + 16'd1;
			else if (editing && up_ten)
				edit_num <= edit_num + 16'd9;
			else if (editing && dn_one)
				edit_num <= edit_num - 16'd1; // RULE_07
			else if (editing && dn_ten)
				edit_num <= edit_num - 16'd9;
			if (cfm && !editing) begin
				editing <= 1'b1;
				edit_num <= (menu_item == 4'd0) ? {9'd0, addr_store} : {8'd0, baud_store};
			end else if (cfm && editing) begin
				// Leaving the field commits with no separate save
				editing <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (cfm && editing && menu_item == 4'd0 && edit_num <= {9'd0, dfkp_pkg::ADDR_MAX})
			addr_store <= edit_num[6:0]; // RULE_09
		else if (cfm && editing && menu_item == 4'd1 && dfkp_pkg::baud_kbps(edit_num[7:0]) != 16'h0000)
			baud_store <= edit_num[7:0];
	end
	// Active values are captured only once per power-up
	logic cfg_taken;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			cfg_taken        <= 1'b0;
			station_addr_out <= '0;
			baud_kbps_out    <= '0;
		end else if (!cfg_taken) begin
			cfg_taken        <= 1'b1;
			station_addr_out <= addr_store; // RULE_04
			baud_kbps_out    <= dfkp_pkg::baud_kbps(baud_store); // RULE_03
		end
	end

	// Fault collection
	logic [31:0] fault_now, fault_lat;
	logic        en_d, rl_d, clr_cmd, rst_req, one_clr, drive_en;
	logic        sw_enable, sw_clear, sw_reset;
	logic [15:0] jog_reg;
	always_comb begin
		fault_now      = f_src & ~dfkp_pkg::RESERVED_MASK; // RULE_17
		fault_now[0]   = fault_now[0] | (temp_s2 > dfkp_pkg::HEAT_LIMIT_C); // RULE_13
		fault_now[4]   = fault_now[4] | (volt_s2 < dfkp_pkg::UNDERVOLT_V); // RULE_14
		fault_now[23]  = fault_now[23] | waf;
		fault_now[29]  = fault_now[29] | eto;
		fault_now[26]  = fault_now[26] | (rl_en && hw_en && !rl_d && !en_d); // RULE_18
	end
	assign rst_req = rst_btn || sw_reset;
	assign one_clr = $onehot(fault_lat) && |(fault_lat & dfkp_pkg::CLEARABLE_MASK); // RULE_20
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			fault_lat <= '0;
			en_d      <= 1'b0;
			rl_d      <= 1'b0;
		end else begin
			en_d <= hw_en;
			rl_d <= rl_en;
			// New events win over the clear in the same cycle
			if (clr_cmd || (rst_req && one_clr))
				fault_lat <= (fault_lat & ~dfkp_pkg::CLEARABLE_MASK) | fault_now; // RULE_19
			else if (rst_req)
				fault_lat <= fault_now;
			else
				fault_lat <= fault_lat | fault_now; // RULE_15 RULE_16
		end
	end
	assign drive_en = hw_en && sw_enable && fault_lat == 32'h0;
	assign safe_out.ready_contact = fault_lat == 32'h0; // RULE_11 RULE_21
	assign safe_out.stage_on      = drive_en;
	assign safe_out.brake_on      = !drive_en;
	assign jog_vel_out = (drive_en && j_p && !j_m) ? jog_reg :
		(drive_en && j_m && !j_p) ? -jog_reg : 16'h0000; // RULE_01

	// Display: lowest numbered fault first, then lowest numbered warning, then status
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			display_out <= dfkp_pkg::DISP_NORMAL;
		end else begin
			display_out <= dfkp_pkg::DISP_NORMAL;
			if (upd)
				display_out <= dfkp_pkg::DISP_UPDATING; // RULE_12
			else if (editing)
				display_out <= dfkp_pkg::DISP_PROGRAM;
			else if (!rl_en && !drive_en)
				display_out <= dfkp_pkg::DISP_RLOCK;
			for (int i = 31; i >= 0; i--) begin
				if (warn[i] && fault_lat == 32'h0)
					display_out <= dfkp_pkg::DISP_WARN_BASE | 8'(i + 1);
			end
			for (int i = 31; i >= 0; i--) begin
				if (fault_lat[i])
					display_out <= 8'(i + 1); // RULE_10
			end
		end
	end

	// Position registers
	logic [31:0] pos_val [dfkp_pkg::NUM_POSREG];
	logic [15:0] pos_en;
	generate
		for (g = 0; g < 16; g++) begin : g_pos
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n)
					pos_hit_out[g] <= 1'b0;
				else
					pos_hit_out[g] <= pos_en[g] && $signed(pos_s2) >= $signed(pos_val[g]); // RULE_02
			end
		end
	endgenerate

	// AXI4-Lite: write taken when both address and data present, one outstanding
	logic       wr_go;
	logic [7:0] wa;
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = !s_axi_rvalid;
	assign wa            = s_axi_awaddr;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dfkp_pkg::RESP_OKAY;
			sw_enable    <= 1'b0;
			sw_clear     <= 1'b0;
			sw_reset     <= 1'b0;
			jog_reg      <= '0;
			pos_en       <= '0;
			for (int i = 0; i < 16; i++)
				pos_val[i] <= '0;
		end else begin
			sw_clear <= 1'b0;
			sw_reset <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= dfkp_pkg::RESP_OKAY;
				if (wa == dfkp_pkg::REG_CTRL && s_axi_wstrb[0]) begin
					sw_enable <= s_axi_wdata[0];
					sw_clear  <= s_axi_wdata[1];
					sw_reset  <= s_axi_wdata[2];
				end else if (wa == dfkp_pkg::REG_JOG_VEL) begin
					if (s_axi_wstrb[0]) jog_reg[7:0]  <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1]) jog_reg[15:8] <= s_axi_wdata[15:8];
				end else if (wa == dfkp_pkg::REG_POS_EN) begin
					if (s_axi_wstrb[0]) pos_en[7:0]  <= s_axi_wdata[7:0];
					if (s_axi_wstrb[1]) pos_en[15:8] <= s_axi_wdata[15:8];
				end else if (wa[7:6] == 2'b01 && wa[1:0] == 2'b00) begin
					for (int b = 0; b < 4; b++)
						if (s_axi_wstrb[b]) pos_val[wa[5:2]][8*b +: 8] <= s_axi_wdata[8*b +: 8];
				end else begin
					s_axi_bresp <= dfkp_pkg::RESP_SLVERR;
				end
			end
		end
	end
	assign clr_cmd = sw_clear;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= dfkp_pkg::RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end else if (s_axi_arvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= dfkp_pkg::RESP_OKAY;
			s_axi_rdata  <= '0;
			if (s_axi_araddr == dfkp_pkg::REG_CTRL)
				s_axi_rdata <= {31'd0, sw_enable};
			else if (s_axi_araddr == dfkp_pkg::REG_JOG_VEL)
				s_axi_rdata <= {16'd0, jog_reg};
			else if (s_axi_araddr == dfkp_pkg::REG_STATUS)
				s_axi_rdata <= {16'd0, advanced_menu_out, editing, drive_en, 5'd0, display_out};
			else if (s_axi_araddr == dfkp_pkg::REG_FAULTS)
				s_axi_rdata <= fault_lat;
			else if (s_axi_araddr == dfkp_pkg::REG_CONFIG)
				s_axi_rdata <= {baud_kbps_out, 1'b0, station_addr_out, baud_store};
			else if (s_axi_araddr == dfkp_pkg::REG_POS_EN)
				s_axi_rdata <= {16'd0, pos_en};
			else if (s_axi_araddr == dfkp_pkg::REG_POS_HIT)
				s_axi_rdata <= {16'd0, pos_hit_out};
			else if (s_axi_araddr[7:6] == 2'b01 && s_axi_araddr[1:0] == 2'b00)
				s_axi_rdata <= pos_val[s_axi_araddr[5:2]];
			else
				s_axi_rresp <= dfkp_pkg::RESP_SLVERR;
		end
	end

	// Checks
	a_fault_safe_state: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_11
		(fault_lat != 32'h0) |-> (!safe_out.ready_contact && !safe_out.stage_on && safe_out.brake_on))
		else $error("fault without safe state");
	a_reserved_never: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_17
		(fault_lat[21] == 1'b0 && fault_lat[30] == 1'b0))
		else $error("reserved fault raised");
	a_clear_keeps_hard: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_19
		(clr_cmd && !rst_req) |=> ((fault_lat & ~dfkp_pkg::CLEARABLE_MASK) ==
		($past(fault_lat) & ~dfkp_pkg::CLEARABLE_MASK | ($past(fault_now) & ~dfkp_pkg::CLEARABLE_MASK))))
		else $error("clear removed a hard fault");
	a_jog_stop_release: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_01
		(!j_p && !j_m) |-> jog_vel_out == 16'h0000)
		else $error("jog moving with no button");
	a_heat_fault: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_13
		(temp_s2 > dfkp_pkg::HEAT_LIMIT_C) |=> fault_lat[0])
		else $error("heat fault missed");
	a_undervolt_fault: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_14
		(volt_s2 < dfkp_pkg::UNDERVOLT_V) |=> fault_lat[4])
		else $error("undervoltage fault missed");
	a_config_frozen: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_04
		cfg_taken |=> $stable(station_addr_out) && $stable(baud_kbps_out))
		else $error("address changed without power cycle");
	a_fault_display: assert property (@(posedge clk_in) disable iff (!rst_n) // RULE_10
		(fault_lat == 32'h1) |=> display_out == 8'h01)
		else $error("fault number not shown");
endmodule // dfkp_panel

// file: dfkp_operator_model.sv
// Operator side model: bouncing keypad contacts and the two enable inputs
module dfkp_operator_model (
	// Clock
	input  wire logic       clk_in,
	// Requests from the bench, keys as {up, down, right, left}
	input  wire logic [3:0] want_keys_in,
	input  wire logic       want_enable_in,
	input  wire logic       together_in,
	// Pins towards the panel
	output logic      [3:0] keys_out,
	output logic            rlock_en_out,
	output logic            hw_en_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] settled = 4'h0;
	logic [3:0] diff    = 4'h0;
	logic [2:0] chat    = 3'h0;
	logic [3:0] gap     = 4'h0;
	// Real contacts chatter after each change, so the panel must filter them
	always_ff @(posedge clk_in) begin
		if (want_keys_in != settled) begin
			diff    <= want_keys_in ^ settled;
			settled <= want_keys_in;
			chat    <= 3'h5;
		end else if (chat != 3'h0) begin
			chat <= chat - 3'h1;
		end
	end
	assign keys_out = settled ^ (chat[0] ? diff : 4'h0);
	// Restart lock first, hardware enable later, unless told to misbehave
	always_ff @(posedge clk_in) begin
		if (!want_enable_in) begin
			rlock_en_out <= 1'b0;
			hw_en_out    <= 1'b0;
			gap          <= 4'h0;
		end else begin
			rlock_en_out <= 1'b1;
			if (gap != 4'hf) begin
				gap <= gap + 4'h1;
			end
			hw_en_out <= together_in || (gap >= 4'h8);
		end
	end
endmodule // dfkp_operator_model

// file: dfkp_panel_tb.sv
// Self-checking bench for the front panel supervisory block
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module dfkp_panel_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, rst_n_in = 1'b0;
	logic [3:0] want_keys = 4'h0, keys;
	logic want_en = 1'b0, together = 1'b0, rlock_en, hw_en;
	logic jog_plus = 1'b0, jog_minus = 1'b0, rst_btn = 1'b0, waf = 1'b0, estop = 1'b0, upd = 1'b0;
	logic [31:0] fault_src = 32'h0, warning = 32'h0, act_pos = 32'h0, wdata = 32'h0, rdata, rval;
	logic [7:0] temp = 8'h19, awaddr = 8'h0, araddr = 8'h0, disp;
	logic [11:0] volt = 12'h0c8;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, adv;
	logic [1:0] bresp, rresp, resp;
	dfkp_pkg::dfkp_safe_t safe;
	logic [15:0] jog_vel, baud, pos_hit;
	logic [6:0] station;
	int fail_count = 0, n_checks = 0, cycles = 0;

	dfkp_operator_model op (.clk_in(clk_in), .want_keys_in(want_keys), .want_enable_in(want_en),
		.together_in(together), .keys_out(keys), .rlock_en_out(rlock_en), .hw_en_out(hw_en));
	dfkp_panel uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .key_up_in(keys[3]), .key_down_in(keys[2]),
		.key_right_in(keys[1]), .key_left_in(keys[0]), .jog_plus_in(jog_plus), .jog_minus_in(jog_minus),
		.restart_lock_enable_in(rlock_en), .hw_enable_in(hw_en), .reset_button_in(rst_btn),
		.fault_src_in(fault_src), .warning_in(warning), .heatsink_temp_in(temp), .dc_bus_volt_in(volt),
		.warn_as_fault_in(waf), .estop_timeout_in(estop), .updating_in(upd), .actual_pos_in(act_pos),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .safe_out(safe), .jog_vel_out(jog_vel), .display_out(disp),
		.advanced_menu_out(adv), .station_addr_out(station), .baud_kbps_out(baud), .pos_hit_out(pos_hit));

	always #2 clk_in = ~clk_in;
	// Whole run needs a few thousand cycles; far beyond that means a hang
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task wc(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic awd, wd;
		awd = 1'b0;
		wd = 1'b0;
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!(awd && wd)) begin
			@(posedge clk_in);
			if (!awd && awready) begin awd = 1'b1; awvalid <= 1'b0; end
			if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
		end
		do @(posedge clk_in); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clk_in);
	endtask
	task rd(input logic [7:0] a);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do @(posedge clk_in); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk_in); while (!rvalid);
		resp = rresp;
		rval = rdata;
		rready <= 1'b0;
		@(posedge clk_in);
	endtask
	task tap(input logic [3:0] k, input int gap);
		want_keys <= want_keys | k; wc(30);
		want_keys <= want_keys & ~k; wc(gap);
	endtask
	task confirm;
		want_keys <= 4'h2; wc(30);
		tap(4'h1, 30);
		want_keys <= 4'h0; wc(100);
	endtask
	task hw_reset(input logic right);
		want_keys <= {2'b00, right, 1'b0};
		want_en <= 1'b0;
		rst_n_in <= 1'b0; wc(10);
		rst_n_in <= 1'b1; wc(60);
		want_keys <= 4'h0; wc(60);
	endtask
	task t_bus;
		rd(8'h30); `CHK(resp, dfkp_pkg::RESP_SLVERR)
		wr(8'h34, 32'h1); `CHK(resp, dfkp_pkg::RESP_SLVERR)
		rd(dfkp_pkg::REG_STATUS); `CHK(resp, dfkp_pkg::RESP_OKAY)
		`CHK(rval, {24'h0, dfkp_pkg::DISP_RLOCK})
		wr(dfkp_pkg::REG_POS_BASE + 8'h0c, 32'h100);
		wr(dfkp_pkg::REG_POS_EN, 32'h8);
		act_pos <= 32'h200; wc(10);
		`CHK(pos_hit, 16'h0008)
		act_pos <= 32'h80; wc(10);
		`CHK(pos_hit, 16'h0000)
	endtask
	task t_idle;
		`CHK(adv, 1'b0)
		`CHK(safe.ready_contact, 1'b1)
		`CHK(disp, dfkp_pkg::DISP_RLOCK)
		`CHK(baud, 16'd10)
	endtask
	task t_jog;
		want_en <= 1'b1; wc(60);
		wr(dfkp_pkg::REG_CTRL, 32'h1);
		wr(dfkp_pkg::REG_JOG_VEL, 32'h0123); wc(10);
		`CHK(safe.stage_on, 1'b1)
		`CHK(disp, dfkp_pkg::DISP_NORMAL)
		jog_plus <= 1'b1; wc(40);
		`CHK(jog_vel, 16'h0123)
		jog_plus <= 1'b0; wc(40);
		`CHK(jog_vel, 16'h0000)
		jog_minus <= 1'b1; wc(40);
		`CHK(jog_vel, 16'hfedd)
		jog_minus <= 1'b0; wc(40);
	endtask
	task t_warn;
		warning <= 32'h2; wc(40);
		`CHK(disp, 8'h82)
		`CHK({safe.ready_contact, safe.stage_on}, 2'b11)
		warning <= 32'h0; wc(40);
	endtask
	task t_heat;
		temp <= 8'h50; wc(40);
		`CHK(safe.ready_contact, 1'b1)
		temp <= 8'h51; wc(40);
		`CHK(disp, 8'h01)
		`CHK(safe, 3'b001)
		temp <= 8'h19; wc(40);
		`CHK(disp, 8'h01)
		wr(dfkp_pkg::REG_CTRL, 32'h3); wc(10);
		`CHK(safe.ready_contact, 1'b1)
	endtask
	task t_volt;
		volt <= 12'h063; wc(40);
		`CHK(disp, 8'h05)
		volt <= 12'h064; wc(40);
		rst_btn <= 1'b1; wc(40);
		rst_btn <= 1'b0; wc(40);
		`CHK(safe.ready_contact, 1'b1)
	endtask
	task t_table;
		int codes[6];
		codes = '{2, 3, 8, 13, 16, 19};
		foreach (codes[i]) begin
			fault_src <= 32'h1 << (codes[i] - 1); wc(40);
			`CHK(disp, 8'(codes[i]))
			fault_src <= 32'h0; wc(40);
			wr(dfkp_pkg::REG_CTRL, 32'h3); wc(10);
			`CHK(safe.ready_contact, 1'b1)
		end
		fault_src <= 32'h20; wc(8);
		fault_src <= 32'h0; wc(40);
		`CHK(safe.ready_contact, 1'b1)
	endtask
	task t_nonclear;
		fault_src <= 32'h0020_0000; wc(40);
		`CHK(safe.ready_contact, 1'b1)
		fault_src <= 32'h0;
		waf <= 1'b1; wc(40);
		`CHK(disp, 8'h18)
		waf <= 1'b0;
		wr(dfkp_pkg::REG_CTRL, 32'h3); wc(10);
		`CHK(safe.ready_contact, 1'b0)
	endtask
	task t_addr;
		confirm();
		tap(4'h8, 100);
		tap(4'h8, 100);
		tap(4'h8, 20);
		tap(4'h8, 100);
		tap(4'h4, 100);
		confirm();
		`CHK(station, 7'h00)
		hw_reset(1'b1);
		`CHK(adv, 1'b1)
		`CHK(station, 7'h0b)
	endtask
	task t_baud;
		tap(4'h8, 100);
		confirm();
		tap(4'h8, 100);
		tap(4'h8, 20);
		tap(4'h8, 100);
		confirm();
		hw_reset(1'b0);
		`CHK(baud, 16'd125)
		rd(dfkp_pkg::REG_CONFIG); `CHK(rval, {16'd125, 8'h0b, 8'h0c})
	endtask
	task t_together;
		want_en <= 1'b0; wc(40);
		`CHK(safe.ready_contact, 1'b1)
		together <= 1'b1;
		want_en <= 1'b1; wc(40);
		`CHK(disp, 8'h1b)
		`CHK(safe.ready_contact, 1'b0)
	endtask

	initial begin
		hw_reset(1'b0);
		t_idle();
		t_bus();
		t_jog();
		t_warn();
		t_heat();
		t_volt();
		t_table();
		t_nonclear();
		hw_reset(1'b0);
		t_addr();
		t_baud();
		t_together();
		test_done();
	end
endmodule // dfkp_panel_tb
